// File: include/rcs_pkg.sv
// Shared constants and types for the regulator control serial link
package rcs_pkg;
   localparam int          CLK_HZ          = 10_000_000;
   localparam int          BUS_MAX_HZ      = 400_000;
   localparam int          SOFT_START_US   = 500;
   localparam int          SOFT_START_CYC  = (CLK_HZ / 1_000_000) * SOFT_START_US;
   localparam int          SOFT_LVL_W      = 4;
   localparam int          SOFT_STEP_CYC   = SOFT_START_CYC / 16;
   localparam int          FILT_LEN        = 3;
   localparam int          SCL_HALF_CYC    = 25;
   localparam int          NUM_REG         = 4;
   localparam logic [6:0]  DEV_ADDR        = 7'h65;
   localparam int          SEL_MSB         = 7;
   localparam int          MODE_LSB        = 0;
   localparam int          EN_BIT          = 7;
   localparam logic [3:0]  CODE_A_DEFAULT  = 4'hF;
   localparam logic [6:0]  CODE_B_DEFAULT  = 7'h00;
   localparam logic [1:0]  MODE_DEFAULT    = 2'h0;

   typedef enum logic [1:0] {
      RCS_MODE_PULSE_SKIP,
      RCS_MODE_LINEAR,
      RCS_MODE_FORCED_BURST,
      RCS_MODE_AUTO_BURST
   } rcs_mode_t;
endpackage : rcs_pkg

// File: include/rcs_link_if.sv
// Two-wire bus between the controller slave and its host master
`timescale 1ns/10ps
interface rcs_link_if;
   logic sclOut;
   logic sclOe;
   logic sdaSlaveOut;
   logic sdaSlaveOe;
   logic sdaHostOut;
   logic sdaHostOe;
   logic scl;
   logic sda;

   // Open-drain wired-and with pull-ups
   assign scl = ~(sclOe & ~sclOut);
   assign sda = ~((sdaSlaveOe & ~sdaSlaveOut) | (sdaHostOe & ~sdaHostOut));

   modport slave (input scl, input sda, output sdaSlaveOut, output sdaSlaveOe);
   modport host  (input scl, input sda, output sclOut, output sclOe,
                  output sdaHostOut, output sdaHostOe);
endinterface : rcs_link_if

// File: rtl/rcs_host.sv
// Host bus master: sends one three-byte write per request
`timescale 1ns/10ps
module rcs_host
   import rcs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   rcs_link_if.host        link,
   input  wire logic       req,
   input  wire logic [7:0] subAddr,
   input  wire logic [7:0] dataByte,
   output logic            busy,
   output logic            done,
   output logic            nack
);
   typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_STOP1, H_STOP2} rcs_hst_t;

   rcs_hst_t    st, next_st;
   logic [5:0]  tick, next_tick;
   logic [26:0] sh, next_sh;
   logic [4:0]  bitCnt, next_bitCnt;
   logic        sclLo, next_sclLo, sdaLo, next_sdaLo;
   logic        next_busy, next_done, next_nack;
   logic [1:0]  sdaSync;
   logic        tickEnd;

   assign tickEnd = (tick == 6'(SCL_HALF_CYC - 1));
   assign link.sclOut     = 1'b0;
   assign link.sdaHostOut = 1'b0;

   // half period of 25 cycles keeps SCL at 200 kHz
   always_comb begin
      next_st = st; next_tick = tickEnd ? 6'h00 : tick + 6'h01;
      next_sh = sh; next_bitCnt = bitCnt; next_sclLo = sclLo; next_sdaLo = sdaLo;
      next_busy = busy; next_done = 1'b0; next_nack = nack;
      unique case (st)
         H_IDLE: begin
            next_tick = 6'h00; next_sclLo = 1'b0; next_sdaLo = 1'b0;
            if (req) begin
               // Ninth bit of each byte left high for the acknowledge
               next_sh = {DEV_ADDR, 1'b0, 1'b1, subAddr, 1'b1, dataByte, 1'b1};
               next_bitCnt = 5'd27; next_busy = 1'b1; next_nack = 1'b0;
               next_st = H_START;
            end
         end
         H_START: if (tickEnd) begin
            next_sdaLo = 1'b1; next_st = H_LOW;
         end
         H_LOW: if (tickEnd) begin
            next_sclLo = 1'b0; next_st = H_HIGH;
         end else if (tick == 6'h01) begin
            next_sclLo = 1'b1;
         end else if (tick == 6'h05) begin
            next_sdaLo = ~sh[26];
         end
         H_HIGH: if (tickEnd) begin
            if (bitCnt == 5'd19 || bitCnt == 5'd10 || bitCnt == 5'd1)
               next_nack = nack | sdaSync[1];
            next_sh = {sh[25:0], 1'b0}; next_bitCnt = bitCnt - 5'd1; next_sclLo = 1'b1;
            next_st = (bitCnt == 5'd1) ? H_STOP1 : H_LOW;
         end
         H_STOP1: if (tickEnd) begin
            next_sdaLo = 1'b1; next_sclLo = 1'b0; next_st = H_STOP2;
         end
         H_STOP2: if (tickEnd) begin
            next_sdaLo = 1'b0; next_busy = 1'b0; next_done = 1'b1; next_st = H_IDLE;
         end
         default: next_st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= H_IDLE; tick <= 6'h00; sh <= 27'h0; bitCnt <= 5'h00;
         sclLo <= 1'b0; sdaLo <= 1'b0; busy <= 1'b0; done <= 1'b0; nack <= 1'b0;
         sdaSync <= 2'b11;
      end else begin
         st <= next_st; tick <= next_tick; sh <= next_sh; bitCnt <= next_bitCnt;
         sclLo <= next_sclLo; sdaLo <= next_sdaLo; busy <= next_busy; done <= next_done;
         nack <= next_nack; sdaSync <= {sdaSync[0], link.sda};
      end
   end

   assign link.sclOe     = sclLo;
   assign link.sdaHostOe = sdaLo;
endmodule : rcs_host

// File: rtl/rcs_slave.sv
// Write-only two-wire slave driving the four regulator control outputs
// What this block does
// - Receive-only slave; SDA driven only to acknowledge
// - Both lines rest high when idle
// - Supply loss clears port, A codes full-scale
// - Master clocks no faster than 400 kHz
// - Glitches filtered on SCL and SDA
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - Eight data bits then acknowledge slot
// - Bytes shifted most significant bit first
// - Master supplies the acknowledge clock
// - Master releases SDA for acknowledge
// - Device holds SDA low through acknowledge high
// - Enable or fault restart runs 500 us soft-start
// - Mode change never restarts soft-start
// - Burst modes switchable at any time
// - Sub-address low bits select mode
// - Data top bit enables or disables regulators
`timescale 1ns/10ps
module rcs_slave
   import rcs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   rcs_link_if.slave              link,
   input  wire logic              supplyOk,
   input  wire logic [NUM_REG-1:0] thermalFault,
   output logic [NUM_REG-1:0]     regEnable,
   output rcs_mode_t              regMode [NUM_REG],
   output logic [3:0]             codeLargeA,
   output logic [3:0]             codeSmallA,
   output logic [6:0]             codeLargeB,
   output logic [6:0]             codeSmallB,
   output logic [NUM_REG*SOFT_LVL_W-1:0] softLevel,
   output logic [NUM_REG-1:0]     softActive
);
   typedef enum logic [1:0] {S_IDLE, S_ADDR, S_SUB, S_DATA} rcs_byte_t;

   // two-stage synchronisers, first stage read only by the second
   logic [1:0] sclSync, sdaSync, supSync;
   logic [FILT_LEN-1:0] sclHist, sdaHist;
   logic sclF, sdaF, sclPrev, sdaPrev, next_sclF, next_sdaF;
   logic sclRise, sclFall, startSeen, stopSeen, portClr;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclSync <= 2'b11; sdaSync <= 2'b11; supSync <= 2'b00;
      end else begin
         sclSync <= {sclSync[0], link.scl};
         sdaSync <= {sdaSync[0], link.sda};
         supSync <= {supSync[0], supplyOk};
      end
   end

   // a level is accepted only after FILT_LEN+1 (4) equal samples
   always_comb begin
      next_sclF = sclF;
      next_sdaF = sdaF;
      if (&{sclHist, sclSync[1]}) next_sclF = 1'b1;
      if (~|{sclHist, sclSync[1]}) next_sclF = 1'b0;
      if (&{sdaHist, sdaSync[1]}) next_sdaF = 1'b1;
      if (~|{sdaHist, sdaSync[1]}) next_sdaF = 1'b0;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclHist <= '1; sdaHist <= '1; sclF <= 1'b1; sdaF <= 1'b1;
         sclPrev <= 1'b1; sdaPrev <= 1'b1;
      end else begin
         sclHist <= {sclHist[FILT_LEN-2:0], sclSync[1]};
         sdaHist <= {sdaHist[FILT_LEN-2:0], sdaSync[1]};
         sclF <= next_sclF; sdaF <= next_sdaF;
         sclPrev <= sclF; sdaPrev <= sdaF;
      end
   end

   assign sclRise   = sclF & ~sclPrev;
   assign sclFall   = ~sclF & sclPrev;
   assign startSeen = sclF & sclPrev & sdaPrev & ~sdaF;
   assign stopSeen  = sclF & sclPrev & ~sdaPrev & sdaF;
   assign portClr   = ~supSync[1];

   // Byte receiver
   rcs_byte_t  bst, next_bst;
   logic [3:0] bitCnt, next_bitCnt;
   logic [7:0] shReg, next_shReg, subReg, next_subReg;
   logic       ackDrv, next_ackDrv, inAck, next_inAck, ackDue, next_ackDue;
   logic       pend, next_pend, locked, next_locked;
   logic [NUM_REG-1:0] holdSel, next_holdSel;
   logic [1:0] holdMode, next_holdMode;
   logic [7:0] holdData, next_holdData;
   logic       commit;

   always_comb begin
      next_bst = bst; next_bitCnt = bitCnt; next_shReg = shReg; next_subReg = subReg;
      next_ackDrv = ackDrv; next_inAck = inAck; next_ackDue = ackDue;
      next_pend = pend; next_locked = locked;
      next_holdSel = holdSel; next_holdMode = holdMode; next_holdData = holdData;
      commit = 1'b0;
      if (startSeen) begin
         next_bst = S_ADDR; next_bitCnt = 4'h0; next_ackDrv = 1'b0;
         next_inAck = 1'b0; next_ackDue = 1'b0;
      end else if (stopSeen) begin
         // A stop in mid-write of a fresh address is ignored
         if (pend && !locked) commit = 1'b1;
         if (!locked) next_pend = 1'b0;
         next_bst = S_IDLE; next_ackDrv = 1'b0; next_inAck = 1'b0;
      end else if (bst != S_IDLE && sclRise && !inAck) begin
         next_shReg = {shReg[6:0], sdaF};
         next_bitCnt = bitCnt + 4'h1;
      end else if (bst != S_IDLE && sclFall) begin
         if (!inAck && bitCnt == 4'd8) begin
            next_inAck = 1'b1;
            next_ackDue = 1'b0;
            unique case (bst)
               S_ADDR: if (shReg == {DEV_ADDR, 1'b0}) begin
                  next_ackDue = 1'b1; next_locked = 1'b1;
               end
               S_SUB:  next_ackDue = 1'b1;
               S_DATA: next_ackDue = 1'b1;
               default: ;
            endcase
            next_ackDrv = next_ackDue;
            if (bst == S_SUB) next_subReg = shReg;
            if (bst == S_DATA) begin
               next_holdSel = subReg[SEL_MSB -: NUM_REG];
               next_holdMode = subReg[MODE_LSB +: 2];
               next_holdData = shReg;
               next_pend = 1'b1; next_locked = 1'b0;
            end
         end else if (inAck) begin
            // release only after the acknowledge high phase ends
            next_ackDrv = 1'b0; next_inAck = 1'b0; next_bitCnt = 4'h0;
            unique case (bst)
               S_ADDR: next_bst = ackDue ? S_SUB : S_IDLE;
               S_SUB:  next_bst = S_DATA;
               S_DATA: next_bst = S_SUB;
               default: next_bst = S_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bst <= S_IDLE; bitCnt <= 4'h0; shReg <= 8'h00; subReg <= 8'h00;
         ackDrv <= 1'b0; inAck <= 1'b0; ackDue <= 1'b0; pend <= 1'b0; locked <= 1'b0;
         holdSel <= '0; holdMode <= MODE_DEFAULT; holdData <= 8'h00;
      end else if (portClr) begin
         bst <= S_IDLE; bitCnt <= 4'h0; shReg <= 8'h00; subReg <= 8'h00;
         ackDrv <= 1'b0; inAck <= 1'b0; ackDue <= 1'b0; pend <= 1'b0; locked <= 1'b0;
         holdSel <= '0; holdMode <= MODE_DEFAULT; holdData <= 8'h00;
      end else begin
         bst <= next_bst; bitCnt <= next_bitCnt; shReg <= next_shReg;
         subReg <= next_subReg; ackDrv <= next_ackDrv; inAck <= next_inAck;
         ackDue <= next_ackDue; pend <= next_pend; locked <= next_locked;
         holdSel <= next_holdSel; holdMode <= next_holdMode; holdData <= next_holdData;
      end
   end

   // open-drain, only ever pulls low for acknowledge
   assign link.sdaSlaveOut = 1'b0;
   assign link.sdaSlaveOe  = ackDrv;

   // Regulator outputs, updated at stop
   logic [NUM_REG-1:0] next_regEnable;
   rcs_mode_t          next_regMode [NUM_REG];
   logic [3:0]         next_codeLargeA, next_codeSmallA;
   logic [6:0]         next_codeLargeB, next_codeSmallB;

   always_comb begin
      next_regEnable = regEnable; next_regMode = regMode;
      next_codeLargeA = codeLargeA; next_codeSmallA = codeSmallA;
      next_codeLargeB = codeLargeB; next_codeSmallB = codeSmallB;
      if (portClr) begin
         next_regEnable = '0;
         next_codeLargeA = CODE_A_DEFAULT; next_codeSmallA = CODE_A_DEFAULT;
      end else if (commit) begin
         for (int i = 0; i < NUM_REG; i++) begin
            if (holdSel[i]) begin
               next_regEnable[i] = holdData[EN_BIT];
               next_regMode[i] = rcs_mode_t'(holdMode);
            end
         end
         if (holdSel[3]) next_codeLargeA = holdData[3:0];
         if (holdSel[2]) next_codeSmallA = holdData[3:0];
         if (holdSel[1]) next_codeLargeB = holdData[6:0];
         if (holdSel[0]) next_codeSmallB = holdData[6:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regEnable <= '0;
         for (int i = 0; i < NUM_REG; i++) regMode[i] <= RCS_MODE_PULSE_SKIP;
         codeLargeA <= CODE_A_DEFAULT; codeSmallA <= CODE_A_DEFAULT;
         codeLargeB <= CODE_B_DEFAULT; codeSmallB <= CODE_B_DEFAULT;
      end else begin
         regEnable <= next_regEnable; regMode <= next_regMode;
         codeLargeA <= next_codeLargeA; codeSmallA <= next_codeSmallA;
         codeLargeB <= next_codeLargeB; codeSmallB <= next_codeSmallB;
      end
   end

   // Soft-start ramp per regulator; mode is not an input here
   logic [NUM_REG-1:0] enPrev, faultPrev;
   logic [NUM_REG-1:0] next_softActive;
   logic [NUM_REG*SOFT_LVL_W-1:0] next_softLevel;
   logic [9:0] stepCnt [NUM_REG];
   logic [9:0] next_stepCnt [NUM_REG];

   always_comb begin
      next_softActive = softActive; next_softLevel = softLevel; next_stepCnt = stepCnt;
      for (int i = 0; i < NUM_REG; i++) begin
         if (!regEnable[i]) begin
            next_softActive[i] = 1'b0;
            next_softLevel[i*SOFT_LVL_W +: SOFT_LVL_W] = '0;
            next_stepCnt[i] = 10'h000;
         end else if ((regEnable[i] && !enPrev[i]) || (faultPrev[i] && !thermalFault[i])) begin
            next_softActive[i] = 1'b1;
            next_softLevel[i*SOFT_LVL_W +: SOFT_LVL_W] = '0;
            next_stepCnt[i] = 10'h000;
         end else if (thermalFault[i]) begin
            next_softActive[i] = 1'b0;
            next_softLevel[i*SOFT_LVL_W +: SOFT_LVL_W] = '0;
         end else if (softActive[i]) begin
            if (stepCnt[i] == 10'(SOFT_STEP_CYC - 1)) begin
               next_stepCnt[i] = 10'h000;
               if (&softLevel[i*SOFT_LVL_W +: SOFT_LVL_W]) next_softActive[i] = 1'b0;
               else next_softLevel[i*SOFT_LVL_W +: SOFT_LVL_W] =
                       softLevel[i*SOFT_LVL_W +: SOFT_LVL_W] + 4'h1;
            end else begin
               next_stepCnt[i] = stepCnt[i] + 10'h001;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         enPrev <= '0; faultPrev <= '0; softActive <= '0; softLevel <= '0;
         for (int i = 0; i < NUM_REG; i++) stepCnt[i] <= 10'h000;
      end else begin
         enPrev <= regEnable; faultPrev <= thermalFault;
         softActive <= next_softActive; softLevel <= next_softLevel; stepCnt <= next_stepCnt;
      end
   end
endmodule : rcs_slave

// File: verification/rcs_link_checker.sv
// Bus-level assertions for the regulator control serial link
`timescale 1ns/10ps
module rcs_link_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sclOe,
   input wire logic sdaHostOe,
   input wire logic sdaSlaveOe
);
   logic       sclQ;
   logic       sdaQ;
   logic       inFrame;
   logic [7:0] bitCnt;
   logic       next_inFrame;
   logic [7:0] next_bitCnt;
   logic       start;
   logic       stop;
   logic       sclRise;

   assign start   = sclQ & scl & sdaQ & ~sda;
   assign stop    = sclQ & scl & ~sdaQ & sda;
   assign sclRise = ~sclQ & scl;

   // Raw wires here: both ends are clean logic, no glitches
   always_comb begin
      next_inFrame = inFrame;
      next_bitCnt  = bitCnt;
      if (start) begin
         next_inFrame = 1'b1;
         next_bitCnt  = 8'h00;
      end else if (stop) begin
         next_inFrame = 1'b0;
      end else if (sclRise) begin
         next_bitCnt = bitCnt + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclQ    <= 1'b1;
         sdaQ    <= 1'b1;
         inFrame <= 1'b0;
         bitCnt  <= 8'h00;
      end else begin
         sclQ    <= scl;
         sdaQ    <= sda;
         inFrame <= next_inFrame;
         bitCnt  <= next_bitCnt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence ackSlotRise;
      sclRise && inFrame && (bitCnt % 9 == 8);
   endsequence
   sequence ackHeldHigh;
      (sdaSlaveOe && !sda) [*8];
   endsequence

   ack_origin_a: assert property ($rose(sdaSlaveOe) |-> inFrame && (bitCnt % 9 == 8))
      else $error("ack raised outside the ninth slot");
   idle_quiet_a: assert property (!inFrame |-> !sdaSlaveOe)
      else $error("slave drives data line on idle bus");
   ack_latency_a: assert property ($rose(sdaSlaveOe) |-> !scl && !$past(scl, 3))
      else $error("ack raised too soon after clock fall");
   ack_slot_a: assert property (sclRise && sdaSlaveOe |-> bitCnt % 9 == 8)
      else $error("ack held across a data bit");
   ack_given_a: assert property (ackSlotRise |-> sdaSlaveOe)
      else $error("byte not acknowledged");
   ack_hold_a: assert property (sclRise && sdaSlaveOe |-> ackHeldHigh)
      else $error("ack not stable low in clock high");
   ack_release_a: assert property ($fell(scl) && sdaSlaveOe |-> ##[1:12] !sdaSlaveOe)
      else $error("ack not released after slot");
   clock_high_a: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   clock_low_a: assert property ($fell(scl) |-> (!scl) [*8])
      else $error("clock low phase too short");
   host_release_a: assert property (ackSlotRise |-> !sdaHostOe)
      else $error("host drives data line in ack slot");
   idle_clock_a: assert property (!inFrame |-> !sclOe)
      else $error("clock held low on idle bus");
endmodule : rcs_link_checker

// File: verification/regulator_control_serial_slave_tb.sv
// Self-checking bench: host and slave joined on one link
`timescale 1ns/10ps
module regulator_control_serial_slave_tb
   import rcs_pkg::*;
;
   logic                         clk;
   logic                         sys_rst;
   logic                         req;
   logic [7:0]                   subAddr;
   logic [7:0]                   dataByte;
   logic                         busy;
   logic                         done;
   logic                         nack;
   logic                         supplyOk;
   logic [NUM_REG-1:0]           thermalFault;
   logic [NUM_REG-1:0]           regEnable;
   rcs_mode_t                    regMode [NUM_REG];
   logic [3:0]                   codeLargeA;
   logic [3:0]                   codeSmallA;
   logic [6:0]                   codeLargeB;
   logic [6:0]                   codeSmallB;
   logic [NUM_REG*SOFT_LVL_W-1:0] softLevel;
   logic [NUM_REG-1:0]           softActive;
   int                           bad_count = 0;
   int                           num_checks = 0;
   int                           cycles = 0;
   int                           mEn [4];
   int                           mMode [4];
   int                           mCode [4];

   rcs_link_if link_i ();

   rcs_host rcs_host_i (.clk(clk), .sys_rst(sys_rst), .link(link_i.host), .req(req),
      .subAddr(subAddr), .dataByte(dataByte), .busy(busy), .done(done), .nack(nack));

   rcs_slave rcs_slave_i (.clk(clk), .sys_rst(sys_rst), .link(link_i.slave),
      .supplyOk(supplyOk), .thermalFault(thermalFault), .regEnable(regEnable),
      .regMode(regMode), .codeLargeA(codeLargeA), .codeSmallA(codeSmallA),
      .codeLargeB(codeLargeB), .codeSmallB(codeSmallB), .softLevel(softLevel),
      .softActive(softActive));

   rcs_link_checker rcs_link_checker_i (.clk(clk), .sys_rst(sys_rst), .scl(link_i.scl),
      .sda(link_i.sda), .sclOe(link_i.sclOe), .sdaHostOe(link_i.sdaHostOe),
      .sdaSlaveOe(link_i.sdaSlaveOe));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task cmp();
      for (int i = 0; i < 4; i++) begin
         check(regEnable[i], mEn[i]);
         check(regMode[i], mMode[i]);
      end
      check(codeLargeA, mCode[3]);
      check(codeSmallA, mCode[2]);
      check(codeLargeB, mCode[1]);
      check(codeSmallB, mCode[0]);
   endtask : cmp

   task wr(input logic [7:0] s, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk);
      #1;
      req = 1'b1;
      subAddr = s;
      dataByte = d;
      @(posedge clk);
      #1;
      req = 1'b0;
      check(busy, 1'b1);
      while (k < 3000) begin
         @(posedge clk);
         #2;
         if (done === 1'b1) k = 9999;
         else k++;
      end
      check(done, 1'b1);
      check(nack, 1'b0);
      check(busy, 1'b0);
      for (int i = 0; i < 4; i++) begin
         if (s[4+i]) begin
            mEn[i] = d[7];
            mMode[i] = s[1:0];
            mCode[i] = (i >= 2) ? d[3:0] : d[6:0];
         end
      end
      repeat (10) @(posedge clk);
      #2;
      cmp();
   endtask : wr

   // Soft-start length is measured, not assumed, from the active flag
   task ramp(input int r);
      int w;
      int n;
      w = 0;
      n = 0;
      while (softActive[r] !== 1'b1 && w < 40) begin
         @(posedge clk);
         #2;
         w++;
      end
      while (softActive[r] === 1'b1 && n < 6000) begin
         @(posedge clk);
         #2;
         n++;
      end
      #2;
      check(n >= SOFT_START_CYC - SOFT_STEP_CYC && n <= SOFT_START_CYC + SOFT_STEP_CYC, 1);
      check(softLevel[r*4+:4], 4'hF);
   endtask : ramp

   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         bad_count++;
         $display("wrong value at %0t: run timed out", $time);
         wrap_up();
      end
   end

   initial begin
      logic [7:0] s;
      sys_rst = 1'b1;
      req = 1'b0;
      subAddr = 8'h00;
      dataByte = 8'h00;
      supplyOk = 1'b1;
      thermalFault = 4'h0;
      mEn = '{0, 0, 0, 0};
      mMode = '{0, 0, 0, 0};
      mCode = '{0, 0, 15, 15};
      s = 8'($urandom(32'h90B91227));
      repeat (4) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      #1;
      cmp();
      $display("test reset done");
      wr(8'h10, 8'h80);
      ramp(0);
      wr(8'h11, 8'h80);
      check(softActive[0], 1'b0);
      check(softLevel[3:0], 4'hF);
      @(posedge clk);
      #1;
      thermalFault = 4'h1;
      repeat (5) @(posedge clk);
      #2;
      check(softLevel[3:0], 4'h0);
      @(posedge clk);
      #1;
      thermalFault = 4'h0;
      ramp(0);
      $display("test soft start done");
      for (int i = 0; i < 8; i++) begin
         s = 8'($urandom);
         s[1:0] = i[1:0];
         wr(s, 8'($urandom));
      end
      $display("test random writes done");
      wr(8'hF3, 8'h85);
      @(posedge clk);
      #1;
      supplyOk = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      supplyOk = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      check(regEnable, 4'h0);
      check(codeLargeA, 4'hF);
      check(codeSmallA, 4'hF);
      mEn = '{0, 0, 0, 0};
      mCode[3] = 15;
      mCode[2] = 15;
      cmp();
      wr(8'hF2, 8'($urandom));
      $display("test supply loss done");
      wrap_up();
   end
endmodule : regulator_control_serial_slave_tb
